//--- rtl/csd_consts.vh
// constants for the curtain status display and gating entry block
// assumes a 200 MHz system clock and a classic wishbone register bus
// What this block does
// - emitter lamps steady; second lit on channel two
// - reduced range flashes lamps; second only channel two
// - receiver lamp green/red by outputs; external error 1 Hz
// - internal fault flashes red 10 Hz, highest priority
// - yellow on: outputs off, interlock blocking, field clear
// - outputs on: yellow follows gating request
// - blue off, steady when taught, slow flash gating
// - blue short flash: interrupted blocking, teach, restart
// - start-up shows all segments, then t and time
// - show mode number; flash it on weak signal
// - error letters F internal, E external, U usage
// - error letter then code digits, repeated cyclically
// - blocking error locks out until power cycle
// - alignment view when never aligned
// - alignment view after 5 s interruption
// - top, middle, bottom segments show beam thirds
// - segment on all clear, flash partial, off none
// - leave alignment view after 5 s clear
// - bridging only if violation within 4 s (2 s mode 4)
// - gating tolerates both sync beams lost 60 s
// - mode from jumper inputs, shown statically
`ifndef CSD_CONSTS_VH
`define CSD_CONSTS_VH
`define CSD_CLK_NS        32'd5
`define CSD_TICK_MS       32'd50
`define CSD_TICK_CYCLES   (`CSD_TICK_MS * 32'd1000000 / `CSD_CLK_NS)
`define CSD_ALIGN_MS      32'd5000
`define CSD_WIN_MS        32'd4000
`define CSD_WIN4_MS       32'd2000
`define CSD_SYNC_MS       32'd60000
`define CSD_STEP_MS       32'd1000
`define CSD_ALIGN_TICKS   (`CSD_ALIGN_MS / `CSD_TICK_MS)
`define CSD_BEAMS         30
`define CSD_THIRD         10
`define CSD_OFF_CTRL      6'h00
`define CSD_OFF_ERR       6'h01
`define CSD_OFF_THRESH    6'h02
`define CSD_OFF_DIV       6'h03
`define CSD_OFF_STATUS    6'h04
`define CSD_THRESH_RST    8'h20
`define CSD_SLOW_TICKS    5'h13
`define CSD_SLOW_HALF     5'h0A
`define CSD_MODE4         2'h1
`define CSD_CAT_NONE      2'h0
`define CSD_CAT_F         2'h1
`define CSD_CAT_E         2'h2
`define CSD_CAT_U         2'h3
`define CSD_SEG_ALL       7'h7F
`define CSD_SEG_OFF       7'h00
`define CSD_SEG_T         7'h78
`define CSD_SEG_F         7'h71
`define CSD_SEG_E         7'h79
`define CSD_SEG_U         7'h3E
`define CSD_SEG_TOP       0
`define CSD_SEG_BOT       3
`define CSD_SEG_MID       6
`endif

//--- rtl/csd_top.v
// curtain status display, lamp control and gating entry check
// assumes synchronous level inputs from the receiver core and a wishbone master
`timescale 1ns/1ps
`include "csd_consts.vh"
module csd_top #(
  parameter [31:0] TICK_CYCLES = `CSD_TICK_CYCLES
) (
  // clock and reset
  input  wire                    clk_i,
  input  wire                    rst_i,
  // wishbone slave
  input  wire                    cyc_i,
  input  wire                    stb_i,
  input  wire                    we_i,
  input  wire [7:0]              adr_i,
  input  wire [3:0]              sel_i,
  input  wire [31:0]             dat_i,
  output reg  [31:0]             dat_o,
  output reg                     ack_o,
  // receiver core state
  input  wire                    safety_switching_outputs_i,
  input  wire                    int_fault_i,
  input  wire                    ext_fault_i,
  input  wire                    restart_interlock_i,
  input  wire                    field_clear_i,
  input  wire [`CSD_BEAMS-1:0]   beams_clear_i,
  input  wire                    sync_a_clear_i,
  input  wire                    sync_b_clear_i,
  input  wire [7:0]              rx_level_i,
  input  wire                    self_test_done_i,
  input  wire [7:0]              resp_time_bcd_i,
  input  wire [1:0]              mode_jumper_i,
  // machine control
  input  wire                    gating_req_i,
  // lamps and readout
  output reg                     tx_primary_status_lamp_o,
  output reg                     tx_secondary_status_lamp_o,
  output reg                     rx_primary_status_lamp_green_o,
  output reg                     rx_primary_status_lamp_red_o,
  output reg                     rx_secondary_status_lamp_o,
  output reg                     rx_function_status_lamp_o,
  output reg  [6:0]              seg_o,
  // gating results and blocking error lockout
  output reg                     timed_gating_function_o,
  output reg                     sync_lost_o,
  output reg                     lockout_o
);

  localparam [1:0] DS_TEST = 2'h0;
  localparam [1:0] DS_RESP = 2'h1;
  localparam [1:0] DS_RUN  = 2'h2;
  localparam [31:0] ALIGN_T = `CSD_ALIGN_TICKS;
  localparam [31:0] WIN_T   = `CSD_WIN_MS / `CSD_TICK_MS;
  localparam [31:0] WIN4_T  = `CSD_WIN4_MS / `CSD_TICK_MS;
  localparam [31:0] SYNC_T  = `CSD_SYNC_MS / `CSD_TICK_MS;
  localparam [31:0] STEP_T  = `CSD_STEP_MS / `CSD_TICK_MS;

  function [6:0] seg_digit;
    input [3:0] d;
    begin
      case (d)
        4'h0: seg_digit = 7'h3F;
        4'h1: seg_digit = 7'h06;
        4'h2: seg_digit = 7'h5B;
        4'h3: seg_digit = 7'h4F;
        4'h4: seg_digit = 7'h66;
        4'h5: seg_digit = 7'h6D;
        4'h6: seg_digit = 7'h7D;
        4'h7: seg_digit = 7'h07;
        4'h8: seg_digit = 7'h7F;
        4'h9: seg_digit = 7'h6F;
        default: seg_digit = `CSD_SEG_OFF;
      endcase
    end
  endfunction

  function third_seg;
    input [`CSD_THIRD-1:0] b;
    input                  ph;
    begin
      if (&b)
        third_seg = 1'b1;
      else if (|b)
        third_seg = ph;
      else
        third_seg = 1'b0;
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  sel;
    integer      i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (sel[i])
          merge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction

  // registers
  reg  [5:0]  ctrl_reg;
  reg  [11:0] err_reg;
  reg  [7:0]  thresh_reg;
  reg  [31:0] div_reg;
  reg  [31:0] tick_cnt_reg;
  reg         tick_reg;
  reg         fast_reg;
  reg  [4:0]  slow_cnt_reg;
  reg  [1:0]  disp_reg;
  reg  [4:0]  step_reg;
  reg  [1:0]  phase_reg;
  reg         aligned_reg;
  reg         align_view_reg;
  reg  [11:0] int_cnt_reg;
  reg  [11:0] clr_cnt_reg;
  reg         req_d_reg;
  reg         win_reg;
  reg  [11:0] win_cnt_reg;
  reg  [11:0] sync_cnt_reg;
  reg         field_d_reg;

  wire        ch2      = ctrl_reg[0];
  wire        range_rd = ctrl_reg[1];
  wire        teaching = ctrl_reg[2];
  wire        taught   = ctrl_reg[3];
  wire        bypass   = ctrl_reg[4];
  wire        restart  = ctrl_reg[5];
  wire [1:0]  err_cat  = err_reg[1:0];
  wire        slow_ph  = slow_cnt_reg < `CSD_SLOW_HALF;
  wire        short_ph = slow_cnt_reg == 5'h0;
  wire        wr       = cyc_i & stb_i & we_i & ack_o;
  wire        sync_bad = ~sync_a_clear_i & ~sync_b_clear_i;
  wire        mode4    = mode_jumper_i == `CSD_MODE4;
  wire [3:0]  mode_num = mode_jumper_i == 2'h0 ? 4'h1 :
                         mode_jumper_i == 2'h1 ? 4'h4 :
                         mode_jumper_i == 2'h2 ? 4'h5 : 4'h6;
  wire        violation = field_d_reg & ~field_clear_i;

  // wishbone: read data loaded at the request edge, write at the ack edge
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o      <= 1'b0;
      dat_o      <= 32'h0;
      ctrl_reg   <= 6'h0;
      err_reg    <= 12'h0;
      thresh_reg <= `CSD_THRESH_RST;
      div_reg    <= TICK_CYCLES;
    end else begin
      ack_o <= cyc_i & stb_i & ~ack_o;
      if (cyc_i & stb_i & ~ack_o) begin
        case (adr_i[7:2])
          `CSD_OFF_CTRL:   dat_o <= {26'h0, ctrl_reg};
          `CSD_OFF_ERR:    dat_o <= {20'h0, err_reg};
          `CSD_OFF_THRESH: dat_o <= {24'h0, thresh_reg};
          `CSD_OFF_DIV:    dat_o <= div_reg;
          `CSD_OFF_STATUS: dat_o <= {22'h0, disp_reg, align_view_reg, aligned_reg,
                                     win_reg, lockout_o, sync_lost_o,
                                     timed_gating_function_o, phase_reg};
          default:         dat_o <= 32'h0;
        endcase
      end
      if (wr & ~lockout_o) begin
        case (adr_i[7:2])
          `CSD_OFF_CTRL:   ctrl_reg <= sel_i[0] ? dat_i[5:0] : ctrl_reg;
          `CSD_OFF_ERR:    err_reg <= {sel_i[1] ? dat_i[11:8] : err_reg[11:8],
                                       sel_i[0] ? dat_i[7:0] : err_reg[7:0]};
          `CSD_OFF_THRESH: thresh_reg <= sel_i[0] ? dat_i[7:0] : thresh_reg;
          `CSD_OFF_DIV:    div_reg <= merge(div_reg, dat_i, sel_i);
          default: ;
        endcase
      end
    end
  end

  // blocking error lockout, held until power cycle
  always @(posedge clk_i) begin
    if (rst_i)
      lockout_o <= 1'b0;
    else if (err_reg[2] && err_cat != `CSD_CAT_NONE)
      lockout_o <= 1'b1;
  end

  // 50 ms tick and flash phases
  always @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt_reg <= 32'h0;
      tick_reg     <= 1'b0;
      fast_reg     <= 1'b0;
      slow_cnt_reg <= 5'h0;
    end else begin
      tick_reg <= 1'b0;
      if (tick_cnt_reg + 32'h1 >= div_reg) begin
        tick_cnt_reg <= 32'h0;
        tick_reg     <= 1'b1;
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 32'h1;
      end
      if (tick_reg) begin
        fast_reg     <= ~fast_reg;
        slow_cnt_reg <= slow_cnt_reg == `CSD_SLOW_TICKS ? 5'h0 : slow_cnt_reg + 5'h1;
      end
    end
  end

  // display sequencing: self test, response time, run
  always @(posedge clk_i) begin
    if (rst_i) begin
      disp_reg  <= DS_TEST;
      step_reg  <= 5'h0;
      phase_reg <= 2'h0;
    end else begin
      case (disp_reg)
        DS_TEST: begin
          if (self_test_done_i) begin
            disp_reg  <= DS_RESP;
            step_reg  <= 5'h0;
            phase_reg <= 2'h0;
          end
        end
        DS_RESP, DS_RUN: begin
          if (disp_reg == DS_RUN && err_cat == `CSD_CAT_NONE) begin
            step_reg  <= 5'h0;
            phase_reg <= 2'h0;
          end else if (tick_reg) begin
            if (step_reg + 5'h1 >= STEP_T) begin
              step_reg <= 5'h0;
              if (phase_reg == 2'h2) begin
                phase_reg <= 2'h0;
                disp_reg  <= DS_RUN;
              end else begin
                phase_reg <= phase_reg + 2'h1;
              end
            end else begin
              step_reg <= step_reg + 5'h1;
            end
          end
        end
        default: disp_reg <= DS_TEST;
      endcase
    end
  end

  // alignment view entry and exit
  always @(posedge clk_i) begin
    if (rst_i) begin
      aligned_reg    <= 1'b0;
      align_view_reg <= 1'b1;
      int_cnt_reg    <= 12'h0;
      clr_cnt_reg    <= 12'h0;
    end else if (!lockout_o) begin
      if (field_clear_i)
        int_cnt_reg <= 12'h0;
      else if (tick_reg && int_cnt_reg != ALIGN_T)
        int_cnt_reg <= int_cnt_reg + 12'h1;
      if (!field_clear_i)
        clr_cnt_reg <= 12'h0;
      else if (tick_reg && clr_cnt_reg != ALIGN_T)
        clr_cnt_reg <= clr_cnt_reg + 12'h1;
      if (clr_cnt_reg == ALIGN_T) begin
        aligned_reg    <= 1'b1;
        align_view_reg <= 1'b0;
      end else if (!aligned_reg) begin
        align_view_reg <= 1'b1;
      end else if (int_cnt_reg == ALIGN_T) begin
        align_view_reg <= 1'b1;
      end
    end
  end

  // gating entry: request first, then violation within the window
  always @(posedge clk_i) begin
    if (rst_i) begin
      req_d_reg               <= 1'b0;
      field_d_reg             <= 1'b1;
      win_reg                 <= 1'b0;
      win_cnt_reg             <= 12'h0;
      sync_cnt_reg            <= 12'h0;
      timed_gating_function_o <= 1'b0;
      sync_lost_o             <= 1'b0;
    end else if (lockout_o) begin
      win_reg                 <= 1'b0;
      timed_gating_function_o <= 1'b0;
    end else begin
      req_d_reg   <= gating_req_i;
      field_d_reg <= field_clear_i;
      if (!gating_req_i) begin
        win_reg                 <= 1'b0;
        timed_gating_function_o <= 1'b0;
      end else if (!req_d_reg && !timed_gating_function_o) begin
        win_reg     <= 1'b1;
        win_cnt_reg <= 12'h0;
      end else if (win_reg) begin
        if (violation && !sync_lost_o) begin
          win_reg                 <= 1'b0;
          timed_gating_function_o <= 1'b1;
        end else if (tick_reg) begin
          if (win_cnt_reg + 12'h1 >= (mode4 ? WIN4_T : WIN_T))
            win_reg <= 1'b0;
          win_cnt_reg <= win_cnt_reg + 12'h1;
        end
      end
      if (!sync_bad) begin
        sync_cnt_reg <= 12'h0;
        sync_lost_o  <= 1'b0;
      end else if (!timed_gating_function_o) begin
        sync_lost_o <= 1'b1;
      end else if (tick_reg) begin
        if (sync_cnt_reg + 12'h1 >= SYNC_T) begin
          sync_lost_o             <= 1'b1;
          timed_gating_function_o <= 1'b0;
        end
        sync_cnt_reg <= sync_cnt_reg + 12'h1;
      end
    end
  end

  // lamps
  always @(posedge clk_i) begin
    if (rst_i) begin
      tx_primary_status_lamp_o       <= 1'b0;
      tx_secondary_status_lamp_o     <= 1'b0;
      rx_primary_status_lamp_green_o <= 1'b0;
      rx_primary_status_lamp_red_o   <= 1'b0;
      rx_secondary_status_lamp_o     <= 1'b0;
      rx_function_status_lamp_o      <= 1'b0;
    end else begin
      if (range_rd) begin
        tx_primary_status_lamp_o   <= slow_ph;
        tx_secondary_status_lamp_o <= ch2 & slow_ph;
      end else begin
        tx_primary_status_lamp_o   <= 1'b1;
        tx_secondary_status_lamp_o <= ch2;
      end
      if (int_fault_i) begin
        rx_primary_status_lamp_green_o <= 1'b0;
        rx_primary_status_lamp_red_o   <= fast_reg;
      end else if (ext_fault_i) begin
        rx_primary_status_lamp_green_o <= 1'b0;
        rx_primary_status_lamp_red_o   <= slow_ph;
      end else begin
        rx_primary_status_lamp_green_o <= safety_switching_outputs_i;
        rx_primary_status_lamp_red_o   <= ~safety_switching_outputs_i;
      end
      if (safety_switching_outputs_i)
        rx_secondary_status_lamp_o <= gating_req_i;
      else
        rx_secondary_status_lamp_o <= restart_interlock_i & field_clear_i;
      if ((restart_interlock_i & ~field_clear_i) | teaching | restart)
        rx_function_status_lamp_o <= short_ph;
      else if (timed_gating_function_o | bypass)
        rx_function_status_lamp_o <= slow_ph;
      else
        rx_function_status_lamp_o <= taught;
    end
  end

  // seven-segment readout
  always @(posedge clk_i) begin
    if (rst_i) begin
      seg_o <= `CSD_SEG_ALL;
    end else if (disp_reg == DS_TEST) begin
      seg_o <= `CSD_SEG_ALL;
    end else if (disp_reg == DS_RESP) begin
      case (phase_reg)
        2'h0:    seg_o <= `CSD_SEG_T;
        2'h1:    seg_o <= seg_digit(resp_time_bcd_i[7:4]);
        default: seg_o <= seg_digit(resp_time_bcd_i[3:0]);
      endcase
    end else if (err_cat != `CSD_CAT_NONE) begin
      case (phase_reg)
        2'h0: begin
          case (err_cat)
            `CSD_CAT_F: seg_o <= `CSD_SEG_F;
            `CSD_CAT_E: seg_o <= `CSD_SEG_E;
            default:    seg_o <= `CSD_SEG_U;
          endcase
        end
        2'h1:    seg_o <= seg_digit(err_reg[7:4]);
        default: seg_o <= seg_digit(err_reg[11:8]);
      endcase
    end else if (align_view_reg) begin
      seg_o                <= `CSD_SEG_OFF;
      seg_o[`CSD_SEG_TOP]  <= third_seg(beams_clear_i[29:20], slow_ph);
      seg_o[`CSD_SEG_MID]  <= third_seg(beams_clear_i[19:10], slow_ph);
      seg_o[`CSD_SEG_BOT]  <= third_seg(beams_clear_i[9:0], slow_ph);
    end else if (rx_level_i < thresh_reg) begin
      seg_o <= slow_ph ? seg_digit(mode_num) : `CSD_SEG_OFF;
    end else begin
      seg_o <= seg_digit(mode_num);
    end
  end

endmodule

//--- test/csd_checker.sv
// concurrent checks on the ports of csd_top
// assumes one clock domain, synchronous active-high reset
`timescale 1ns/1ps
`include "csd_consts.vh"
module csd_checker #(
  parameter [31:0] TICK_CYCLES = 32'd4
) (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       cyc_i,
  input wire logic       stb_i,
  input wire logic       ack_o,
  input wire logic       safety_switching_outputs_i,
  input wire logic       int_fault_i,
  input wire logic       ext_fault_i,
  input wire logic       restart_interlock_i,
  input wire logic       field_clear_i,
  input wire logic       gating_req_i,
  input wire logic       self_test_done_i,
  input wire logic       rx_primary_status_lamp_green_o,
  input wire logic       rx_primary_status_lamp_red_o,
  input wire logic       rx_secondary_status_lamp_o,
  input wire logic [6:0] seg_o,
  input wire logic       timed_gating_function_o,
  input wire logic       lockout_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // lamp checks apply once running and not locked out, except the internal fault check, which applies always
  wire run_ok = self_test_done_i && !lockout_o;
  wire no_flt = !int_fault_i && !ext_fault_i;
  sequence s_take;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_ack;
    ack_o ##1 !ack_o;
  endsequence
  AST_WB_ACK: assert property (s_take |=> s_ack)
    else $error("bus ack not a single pulse one cycle after request");
  AST_GREEN_ON: assert property ((run_ok && no_flt && safety_switching_outputs_i)[*2]
    |-> rx_primary_status_lamp_green_o && !rx_primary_status_lamp_red_o)
    else $error("receiver lamp not green with outputs on");
  AST_RED_ON: assert property ((run_ok && no_flt && !safety_switching_outputs_i)[*2]
    |-> rx_primary_status_lamp_red_o && !rx_primary_status_lamp_green_o)
    else $error("receiver lamp not red with outputs off");
  AST_INT_FAULT: assert property (int_fault_i[*2] |-> !rx_primary_status_lamp_green_o)
    else $error("green lamp lit during internal fault");
  AST_YEL_READY: assert property ((run_ok && !safety_switching_outputs_i
    && restart_interlock_i && field_clear_i)[*2] |-> rx_secondary_status_lamp_o)
    else $error("yellow lamp dark while unlock possible");
  AST_YEL_REQ: assert property ((run_ok && safety_switching_outputs_i && gating_req_i)[*2]
    |-> rx_secondary_status_lamp_o)
    else $error("yellow lamp dark with gating request");
  AST_YEL_NOREQ: assert property ((run_ok && safety_switching_outputs_i && !gating_req_i)[*2]
    |-> !rx_secondary_status_lamp_o)
    else $error("yellow lamp lit without gating request");
  AST_SELF_TEST: assert property ((!self_test_done_i)[*2] |-> seg_o == `CSD_SEG_ALL)
    else $error("readout not all segments during self test");
  AST_BRIDGE_CAUSE: assert property ($rose(timed_gating_function_o)
    |-> $past(gating_req_i && !field_clear_i) && !lockout_o)
    else $error("bridging without request and violation");
  AST_BRIDGE_END: assert property (!gating_req_i |=> !timed_gating_function_o)
    else $error("bridging kept after request dropped");
  AST_LOCK_STICKY: assert property (lockout_o |=> lockout_o)
    else $error("lockout released without reset");
endmodule
bind csd_top csd_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .safety_switching_outputs_i, .int_fault_i,
  .ext_fault_i, .restart_interlock_i, .field_clear_i, .gating_req_i, .self_test_done_i,
  .rx_primary_status_lamp_green_o, .rx_primary_status_lamp_red_o,
  .rx_secondary_status_lamp_o, .seg_o, .timed_gating_function_o, .lockout_o
);

//--- test/csd_ctrl_model.sv
// machine control model: gating request, then a field violation
// assumes go_i pulses one cycle; delays counted in clock cycles
`timescale 1ns/1ps
module csd_ctrl_model (
  // clock
  input  wire        clk_i,
  // bench control
  input  wire        go_i,
  input  wire        req_i,
  input  wire        fc_i,
  input  wire [15:0] dly_i,
  input  wire [15:0] hold_i,
  // towards the block, busy_o towards the bench
  output wire        gating_req_o,
  output wire        field_clear_o,
  output wire        busy_o
);
  reg [1:0]  st_reg  = 2'h0;
  reg [15:0] cnt_reg = 16'h0;
  assign busy_o        = st_reg != 2'h0;
  assign gating_req_o  = req_i | busy_o;
  assign field_clear_o = fc_i & (st_reg != 2'h2);
  always @(posedge clk_i) begin
    if (st_reg == 2'h0 && go_i) begin
      st_reg  <= 2'h1;
      cnt_reg <= dly_i;
    end else if (cnt_reg != 16'h0) begin
      cnt_reg <= cnt_reg - 16'h1;
    end else if (st_reg == 2'h1) begin
      st_reg  <= 2'h2;
      cnt_reg <= hold_i;
    end else if (st_reg == 2'h2) begin
      st_reg <= 2'h0;
    end
  end
endmodule

//--- test/csd_top_tb_top.sv
// self-checking bench for csd_top
// assumes tick of four clocks, partner drives request and field
`timescale 1ns/1ps
`include "csd_consts.vh"
module csd_top_tb_top;
  logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic        ack_o, field_clear_i, gating_req_i, busy, go = 0, fcb = 0, rq = 0;
  logic        safety_switching_outputs_i = 0, int_fault_i = 0, ext_fault_i = 0;
  logic        restart_interlock_i = 0, sync_a_clear_i = 1, sync_b_clear_i = 1;
  logic        self_test_done_i = 0;
  logic [29:0] beams_clear_i = 30'h3FFFFFFF;
  logic [7:0]  rx_level_i = 8'hFF, resp_time_bcd_i = 8'h12;
  logic [1:0]  mode_jumper_i = 2'h0;
  logic [15:0] dly = 16'h0, hold = 16'h0;
  logic        tx_primary_status_lamp_o, tx_secondary_status_lamp_o, rx_function_status_lamp_o;
  logic        rx_primary_status_lamp_green_o, rx_primary_status_lamp_red_o;
  logic        rx_secondary_status_lamp_o, timed_gating_function_o, sync_lost_o, lockout_o;
  logic [6:0]  seg_o;
  logic [6:0]  digs [0:9] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07, 7'h7F, 7'h6F};
  logic [6:0]  lets [1:3] = '{`CSD_SEG_F, `CSD_SEG_E, `CSD_SEG_U};
  int          mdig [0:3] = '{1, 4, 5, 6};
  int          errors = 0, checks_done = 0, n;
  wire  [5:0]  lamps = {tx_primary_status_lamp_o, tx_secondary_status_lamp_o,
    rx_primary_status_lamp_green_o, rx_primary_status_lamp_red_o,
    rx_secondary_status_lamp_o, rx_function_status_lamp_o};
  always #2.5 clk_i = ~clk_i;
  csd_top #(.TICK_CYCLES(32'd4)) dut (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
    .safety_switching_outputs_i, .int_fault_i, .ext_fault_i, .restart_interlock_i,
    .field_clear_i, .beams_clear_i, .sync_a_clear_i, .sync_b_clear_i, .rx_level_i,
    .self_test_done_i, .resp_time_bcd_i, .mode_jumper_i, .gating_req_i,
    .tx_primary_status_lamp_o, .tx_secondary_status_lamp_o, .rx_primary_status_lamp_green_o,
    .rx_primary_status_lamp_red_o, .rx_secondary_status_lamp_o, .rx_function_status_lamp_o,
    .seg_o, .timed_gating_function_o, .sync_lost_o, .lockout_o
  );
  csd_ctrl_model partner (
    .clk_i, .go_i(go), .req_i(rq), .fc_i(fcb), .dly_i(dly), .hold_i(hold),
    .gating_req_o(gating_req_i), .field_clear_o(field_clear_i), .busy_o(busy)
  );
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask
  task automatic step(input int c);
    repeat (c) @(posedge clk_i);
    #1;
  endtask
  task automatic wait_seg(input logic [6:0] e, input int lim);
    int k;
    k = 0;
    while (seg_o !== e && k < lim) begin
      step(1);
      k++;
    end
    check("seg", {25'h0, seg_o}, {25'h0, e});
  endtask
  task automatic lamp(input logic [7:0] ctl, input logic [5:0] in, input logic [5:0] ehi,
                      input logic [5:0] elo, input logic slow);
    logic [5:0] hi;
    logic [5:0] lo;
    int         bon;
    wb(1'b1, 8'h00, {24'h0, ctl});
    @(posedge clk_i);
    {safety_switching_outputs_i, restart_interlock_i, fcb, rq, int_fault_i, ext_fault_i} <= in;
    step(20);
    hi = 6'h00;
    lo = 6'h00;
    bon = 0;
    repeat (400) begin
      step(1);
      hi |= lamps;
      lo |= ~lamps;
      bon += int'(rx_function_status_lamp_o);
    end
    check("lamps_lit", {26'h0, hi}, {26'h0, ehi});
    check("lamps_dark", {26'h0, lo}, {26'h0, elo});
    check("blue_long", {31'h0, bon > 120}, {31'h0, slow});
  endtask
  task automatic gate(input logic [1:0] jm, input logic [15:0] d, input logic [15:0] h);
    @(posedge clk_i);
    mode_jumper_i <= jm;
    hold <= h;
    dly <= d;
    repeat (8) @(posedge clk_i);
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
  endtask
  task automatic gate_chk(input logic [1:0] jm, input logic [15:0] d, input logic exp);
    logic seen;
    int   k;
    gate(jm, d, 16'd100);
    seen = 1'b0;
    k = 0;
    do begin
      step(1);
      seen |= timed_gating_function_o;
      k++;
    end while (busy && k < 2000);
    check("bridge", {31'h0, seen}, {31'h0, exp});
    step(10);
  endtask
  initial begin
    repeat (40000) @(posedge clk_i);
    errors++;
    give_verdict;
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    step(1);
    check("seg_reset", {25'h0, seg_o}, 32'h7F);
    wb(1'b0, 8'h08, 32'h0);
    check("thresh", rd, 32'h20);
    wb(1'b0, 8'h0C, 32'h0);
    check("div", rd, 32'h4);
    wb(1'b0, 8'h3C, 32'h0);
    check("unmapped", rd, 32'h0);
    @(posedge clk_i);
    self_test_done_i <= 1'b1;
    wait_seg(`CSD_SEG_T, 200);
    wait_seg(digs[1], 200);
    wait_seg(digs[2], 200);
    wait_seg(7'h49, 200);
    @(posedge clk_i);
    beams_clear_i <= {10'h155, 10'h3FF, 10'h000};
    wait_seg(7'h41, 300);
    wait_seg(7'h40, 300);
    @(posedge clk_i);
    beams_clear_i <= 30'h3FFFFFFF;
    fcb <= 1'b1;
    step(200);
    check("align_hold", {25'h0, seg_o}, 32'h49);
    wait_seg(digs[1], 400);
    for (n = 0; n < 4; n++) begin
      @(posedge clk_i);
      mode_jumper_i <= n[1:0];
      wait_seg(digs[mdig[n]], 50);
    end
    @(posedge clk_i);
    mode_jumper_i <= 2'h0;
    rx_level_i <= 8'h10;
    wait_seg(`CSD_SEG_OFF, 200);
    wait_seg(digs[1], 200);
    @(posedge clk_i);
    rx_level_i <= 8'hFF;
    fcb <= 1'b0;
    step(200);
    check("mode_hold", {25'h0, seg_o}, {25'h0, digs[1]});
    wait_seg(7'h49, 400);
    @(posedge clk_i);
    fcb <= 1'b1;
    int_fault_i <= 1'b1;
    wait_seg(digs[1], 600);
    for (n = 1; n < 4; n++) begin
      wb(1'b1, 8'h04, {20'h0, 4'h2, 4'h1, 2'h0, n[1:0]});
      wait_seg(lets[n], 300);
      wait_seg(digs[1], 150);
      wait_seg(digs[2], 150);
      wait_seg(lets[n], 150);
    end
    wb(1'b1, 8'h04, 32'h0);
    lamp(8'h01, 6'b101100, 6'b111010, 6'b000101, 1'b0);
    lamp(8'h02, 6'b011000, 6'b100110, 6'b111001, 1'b0);
    lamp(8'h03, 6'b010000, 6'b110101, 6'b111011, 1'b0);
    lamp(8'h08, 6'b101010, 6'b100101, 6'b011110, 1'b1);
    lamp(8'h10, 6'b001001, 6'b100101, 6'b011111, 1'b1);
    lamp(8'h24, 6'b101000, 6'b101001, 6'b010111, 1'b0);
    lamp(8'h00, 6'b101000, 6'b101000, 6'b010111, 1'b0);
    gate_chk(2'h0, 16'd280, 1'b1);
    gate_chk(2'h1, 16'd280, 1'b0);
    gate_chk(2'h0, 16'd600, 1'b0);
    gate_chk(2'h1, 16'd100, 1'b1);
    gate(2'h0, 16'd40, 16'd12000);
    step(100);
    check("bridge_on", {31'h0, timed_gating_function_o}, 32'h1);
    @(posedge clk_i);
    sync_a_clear_i <= 1'b0;
    sync_b_clear_i <= 1'b0;
    step(1000);
    check("bridge_kept", {31'h0, timed_gating_function_o}, 32'h1);
    check("sync_ok", {31'h0, sync_lost_o}, 32'h0);
    n = 0;
    while (sync_lost_o !== 1'b1 && n < 7000) begin
      step(1);
      n++;
    end
    check("sync_lost", {31'h0, sync_lost_o}, 32'h1);
    check("bridge_off", {31'h0, timed_gating_function_o}, 32'h0);
    wb(1'b1, 8'h04, 32'h5);
    step(2);
    check("lockout", {31'h0, lockout_o}, 32'h1);
    wb(1'b1, 8'h08, 32'h11);
    wb(1'b0, 8'h08, 32'h0);
    check("thresh_locked", rd, 32'h20);
    wb(1'b0, 8'h10, 32'h0);
    check("status", rd & 32'h1C, 32'h18);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    step(2);
    check("lockout_clr", {31'h0, lockout_o}, 32'h0);
    give_verdict;
  end
endmodule
